/* design/mii_if.sv */
// Wires of the nibble-wide link between the physical layer and the MAC side.
// Assumes the physical layer end sources both data clocks.
`default_nettype none
interface mii_if;
  logic       tx_clk;
  logic       rx_clk;
  logic       tx_en;
  logic       tx_er;
  logic [3:0] txd;
  logic       rx_dv;
  logic       rx_er;
  logic [3:0] rxd;
  logic       crs;
  logic       col;
  logic       mdc;

  modport phy (
    output tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col,
    input  tx_en, tx_er, txd, mdc
  );

  modport mac (
    input  tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col,
    output tx_en, tx_er, txd, mdc
  );
endinterface
`default_nettype wire

/* design/mii_mac_end.sv */
// MAC side end of the nibble link: frames bytes into nibbles with preamble,
// strips the preamble on receive, and brings carrier and collision home in half duplex.
// Assumes tx user ports run on m.tx_clk and rx user ports on m.rx_clk.
`default_nettype none
module mii_mac_end
  import mii_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              full_duplex,
  output logic                   carrier,
  output logic                   collision,
  input  wire logic              tx_valid,
  input  wire logic [BYTE_W-1:0] tx_data,
  input  wire logic              tx_last,
  input  wire logic              tx_err,
  output logic                   tx_ready,
  output logic                   rx_valid,
  output logic      [BYTE_W-1:0] rx_data,
  output logic                   rx_last,
  output logic                   rx_bad,
  output logic                   rx_false_carrier,
  mii_if.mac                     m
);

  typedef enum logic [2:0] {T_IDLE, T_PRE, T_SFD, T_LO, T_HI, T_ERR} tx_state_t;
  typedef enum logic [1:0] {R_HUNT, R_LO, R_HI} rx_state_t;

  tx_state_t         tstate;
  rx_state_t         rstate;
  logic [1:0]        rst_tx_sh;
  logic [1:0]        rst_rx_sh;
  logic [3:0]        cnt;
  logic [BYTE_W-1:0] cur;
  logic              cur_last;
  logic [NIB_W-1:0]  lo;
  logic [BYTE_W-1:0] pend;
  logic              pend_ok;
  logic              err_seen;
  logic              dv_q;
  logic [1:0]        crs_sh;
  logic [1:0]        col_sh;
  logic [4:0]        mdc_cnt;

  // ------------------------------------------------------------
  // Reset into the link domains
  // ------------------------------------------------------------
  always_ff @(posedge m.tx_clk) begin
    rst_tx_sh <= {rst_tx_sh[0], rst_n};
  end

  always_ff @(posedge m.rx_clk) begin
    rst_rx_sh <= {rst_rx_sh[0], rst_n};
  end

  // ------------------------------------------------------------
  // Transmit framing
  // ------------------------------------------------------------
  // Fifteen preamble nibbles, the delimiter, then each byte low nibble
  // first. A byte missing when wanted ends the frame with one error nibble.
  assign tx_ready = (tstate == T_SFD) | ((tstate == T_HI) & !cur_last);

  always_ff @(posedge m.tx_clk) begin
    if (!rst_tx_sh[1]) begin
      tstate   <= T_IDLE;
      m.tx_en  <= 1'b0;
      m.tx_er  <= 1'b0;
      m.txd    <= NIBBLE_ZERO;
      cnt      <= 4'h0;
      cur      <= '0;
      cur_last <= 1'b0;
    end else begin
      unique case (tstate)
        T_IDLE: if (tx_valid) begin
          m.tx_en <= 1'b1;
          m.txd   <= PRE_NIBBLE;
          cnt     <= 4'h1;
          tstate  <= T_PRE;
        end
        T_PRE: if (cnt == PRE_COUNT) begin
          m.txd  <= SFD_NIBBLE;
          tstate <= T_SFD;
        end else begin
          cnt <= cnt + 4'h1;
        end
        T_LO: begin
          m.txd  <= cur[7:4];
          tstate <= T_HI;
        end
        T_SFD, T_HI: if ((tstate == T_HI) && cur_last) begin
          m.tx_en <= 1'b0;
          m.tx_er <= 1'b0;
          m.txd   <= NIBBLE_ZERO;
          tstate  <= T_IDLE;
        end else if (tx_valid) begin
          cur      <= tx_data;
          cur_last <= tx_last;
          m.txd    <= tx_data[3:0];
          m.tx_er  <= tx_err;
          tstate   <= T_LO;
        end else begin
          m.txd   <= NIBBLE_ZERO;
          m.tx_er <= 1'b1;
          tstate  <= T_ERR;
        end
        T_ERR: begin
          m.tx_en <= 1'b0;
          m.tx_er <= 1'b0;
          tstate  <= T_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receive deframing
  // ------------------------------------------------------------
  // Each byte is held back one byte so the last can be flagged when
  // valid falls; a frame that saw an error or ends on a half byte is bad.
  always_ff @(posedge m.rx_clk) begin
    if (!rst_rx_sh[1]) begin
      rstate           <= R_HUNT;
      dv_q             <= 1'b0;
      lo               <= NIBBLE_ZERO;
      pend             <= '0;
      pend_ok          <= 1'b0;
      err_seen         <= 1'b0;
      rx_valid         <= 1'b0;
      rx_data          <= '0;
      rx_last          <= 1'b0;
      rx_bad           <= 1'b0;
      rx_false_carrier <= 1'b0;
    end else begin
      rx_valid         <= 1'b0;
      rx_last          <= 1'b0;
      rx_bad           <= 1'b0;
      dv_q             <= m.rx_dv;
      rx_false_carrier <= !m.rx_dv & m.rx_er & (m.rxd == FALSE_CARRIER);
      if (m.rx_dv) begin
        if (m.rx_er) begin
          err_seen <= 1'b1;
        end
        unique case (rstate)
          R_HUNT: if (m.rxd == SFD_NIBBLE) begin
            rstate <= R_LO;
          end
          R_LO: begin
            lo     <= m.rxd;
            rstate <= R_HI;
          end
          R_HI: begin
            if (pend_ok) begin
              rx_valid <= 1'b1;
              rx_data  <= pend;
            end
            pend    <= {m.rxd, lo};
            pend_ok <= 1'b1;
            rstate  <= R_LO;
          end
        endcase
      end else begin
        if (dv_q && pend_ok) begin
          rx_valid <= 1'b1;
          rx_data  <= pend;
          rx_last  <= 1'b1;
          rx_bad   <= err_seen | (rstate == R_HI);
        end
        pend_ok  <= 1'b0;
        err_seen <= 1'b0;
        rstate   <= R_HUNT;
      end
    end
  end

  // ------------------------------------------------------------
  // Carrier, collision and management clock
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    crs_sh <= {crs_sh[0], m.crs};
    col_sh <= {col_sh[0], m.col};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      carrier   <= 1'b0;
      collision <= 1'b0;
    end else begin
      carrier   <= crs_sh[1] & !full_duplex;
      collision <= col_sh[1] & !full_duplex;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mdc_cnt <= 5'h0;
      m.mdc   <= 1'b0;
    end else if (mdc_cnt == MDC_HALF_LAST) begin
      mdc_cnt <= 5'h0;
      m.mdc   <= !m.mdc;
    end else begin
      mdc_cnt <= mdc_cnt + 5'h1;
    end
  end

endmodule
`default_nettype wire

/* design/mii_phy_end.sv */
// Physical layer end of the nibble link: takes transmit nibbles, drives
// the line symbol stream, delivers received nibbles, carrier and collision.
// Assumes the medium side runs on clk_line, which also clocks the link.
`default_nettype none
module mii_phy_end
  import mii_pkg::*;
(
  input  wire logic             clk_line,
  input  wire logic             rst_n,
  input  wire logic             loopback,
  input  wire logic             full_duplex,
  input  wire logic             speed_10,
  input  wire logic             med_rx_valid,
  input  wire logic [NIB_W-1:0] med_rx_nibble,
  input  wire logic             med_rx_err,
  input  wire logic             med_false_carrier,
  input  wire logic             med_col,
  input  wire logic             med_sqe,
  output logic                  line_tx_valid,
  output logic      [SYM_W-1:0] line_tx_sym,
  mii_if.phy                    m
);

  // ------------------------------------------------------------
  // Clocks and reset
  // ------------------------------------------------------------
  logic             rst_meta;
  logic             rst_line_n;
  logic [2:0]       mode_meta;
  logic [2:0]       mode_sync;
  logic             loop_s;
  logic             fdx_s;
  logic             slow_s;
  logic             tx_en_q;
  logic             tx_er_q;
  logic [NIB_W-1:0] txd_q;
  logic             src_dv;
  logic [NIB_W-1:0] src_d;
  logic             src_err;
  logic             src_fc;
  logic             next_col;
  logic             rx_dv_q;
  logic             rx_er_q;
  logic [NIB_W-1:0] rxd_q;
  logic             crs_q;
  logic             col_q;

  // Both data clocks come straight from the line clock.
  assign m.tx_clk = clk_line;
  assign m.rx_clk = clk_line;

  always_ff @(posedge clk_line) begin
    rst_meta   <= rst_n;
    rst_line_n <= rst_meta;
  end

  always_ff @(posedge clk_line) begin
    mode_meta <= {loopback, full_duplex, speed_10};
    mode_sync <= mode_meta;
  end

  assign loop_s = mode_sync[2];
  assign fdx_s  = mode_sync[1];
  assign slow_s = mode_sync[0];

  // ------------------------------------------------------------
  // Transmit capture
  // ------------------------------------------------------------
  // The nibble is only taken while enable is high; the error input is
  // masked when idle or at the low rate, so the reserved idle-with-error
  // code behaves as plain idle.
  always_ff @(posedge clk_line) begin
    if (!rst_line_n) begin
      tx_en_q <= 1'b0;
      tx_er_q <= 1'b0;
      txd_q   <= NIBBLE_ZERO;
    end else begin
      tx_en_q <= m.tx_en;
      txd_q   <= m.tx_en ? m.txd : NIBBLE_ZERO;
      tx_er_q <= m.tx_en & m.tx_er & !slow_s;
    end
  end

  // ------------------------------------------------------------
  // Line transmit
  // ------------------------------------------------------------
  // An errored nibble is replaced in place by the invalid symbol.
  always_ff @(posedge clk_line) begin
    if (!rst_line_n) begin
      line_tx_valid <= 1'b0;
    end else begin
      line_tx_valid <= tx_en_q & !loop_s;
    end
  end

  always_ff @(posedge clk_line) begin
    if (!rst_line_n) begin
      line_tx_sym <= '0;
    end else begin
      if (tx_er_q) begin
        line_tx_sym <= SYM_ERROR;
      end else begin
        line_tx_sym <= {1'b0, txd_q};
      end
    end
  end

  // ------------------------------------------------------------
  // Receive source
  // ------------------------------------------------------------
  // Transmit nibbles reach the receive path only in loopback, whatever
  // the duplex mode.
  always_comb begin
    if (loop_s) begin
      src_dv  = tx_en_q;
      src_d   = txd_q;
      src_err = tx_er_q;
      src_fc  = 1'b0;
    end else begin
      src_dv  = med_rx_valid;
      src_d   = med_rx_nibble;
      src_err = med_rx_err;
      src_fc  = med_false_carrier;
    end
  end

  // ------------------------------------------------------------
  // Receive outputs
  // ------------------------------------------------------------
  // The medium presents preamble and the whole start delimiter inside its
  // valid window and no end delimiter, so valid simply follows it.
  always_ff @(posedge clk_line) begin
    if (!rst_line_n) begin
      rx_dv_q <= 1'b0;
    end else begin
      rx_dv_q <= src_dv;
    end
  end

  always_ff @(posedge clk_line) begin
    if (!rst_line_n) begin
      rx_er_q <= 1'b0;
      rxd_q   <= NIBBLE_ZERO;
    end else begin
      if (src_dv) begin
        rxd_q   <= src_d;
        rx_er_q <= src_err;
      end else if (src_fc) begin
        rxd_q   <= FALSE_CARRIER;
        rx_er_q <= 1'b1;
      end else begin
        rxd_q   <= NIBBLE_ZERO;
        rx_er_q <= 1'b0;
      end
    end
  end

  assign m.rx_dv = rx_dv_q;
  assign m.rx_er = rx_er_q;
  assign m.rxd   = rxd_q;

  // ------------------------------------------------------------
  // Carrier and collision
  // ------------------------------------------------------------
  // Collision is suppressed in loopback, where the medium is detached.
  // In full duplex both outputs still follow activity; the MAC side
  // must not act on them there.
  assign next_col = !loop_s & (med_col | (slow_s & med_sqe));

  always_ff @(posedge clk_line) begin
    if (!rst_line_n) begin
      col_q <= 1'b0;
    end else begin
      col_q <= next_col;
    end
  end

  always_ff @(posedge clk_line) begin
    if (!rst_line_n) begin
      crs_q <= 1'b0;
    end else begin
      crs_q <= tx_en_q | src_dv | (!loop_s & med_rx_valid) | next_col;
    end
  end

  assign m.col = col_q;
  assign m.crs = crs_q & (fdx_s | 1'b1);

endmodule
`default_nettype wire

/* design/mii_pkg.sv */
// Shared constants for both ends of the nibble-wide media independent link.
// Assumes both ends import the whole package in their module headers.
`default_nettype none
package mii_pkg;
  // ------------------------------------------------------------
  // Data path
  // ------------------------------------------------------------
  localparam int         NIB_W         = 4;
  localparam int         BYTE_W        = 8;
  localparam int         SYM_W         = 5;
  localparam logic [3:0] PRE_NIBBLE    = 4'h5;
  localparam logic [3:0] SFD_NIBBLE    = 4'hD;
  localparam logic [3:0] FALSE_CARRIER = 4'hE;
  localparam logic [3:0] NIBBLE_ZERO   = 4'h0;
  localparam logic [3:0] PRE_COUNT     = 4'hF;
  // Line symbol with the top bit set is outside the valid data set.
  localparam logic [4:0] SYM_ERROR     = 5'h10;
  // ------------------------------------------------------------
  // Management clock timing
  // ------------------------------------------------------------
  localparam int         CLK_SYS_NS        = 20;
  localparam int         MDC_PHASE_MIN_NS  = 160;
  localparam int         MDC_PERIOD_MIN_NS = 400;
  localparam int         MDC_PHASE_CYC     = (MDC_PHASE_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int         MDC_PERIOD_CYC    = (MDC_PERIOD_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int         MDC_HALF_CYC      = (MDC_PHASE_CYC > (MDC_PERIOD_CYC + 1) / 2) ?
                                             MDC_PHASE_CYC : (MDC_PERIOD_CYC + 1) / 2;
  localparam logic [4:0] MDC_HALF_LAST     = 5'(MDC_HALF_CYC - 1);
endpackage
`default_nettype wire

/* tb/mii_checker.sv */
// Concurrent checks on the wires of the nibble link.
// Assumes it is instantiated beside the interface that joins both ends.
`default_nettype none
module mii_checker (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       tx_clk,
  input wire logic       rx_clk,
  input wire logic       tx_en,
  input wire logic       tx_er,
  input wire logic [3:0] txd,
  input wire logic       rx_dv,
  input wire logic       rx_er,
  input wire logic [3:0] rxd,
  input wire logic       crs,
  input wire logic       col,
  input wire logic       mdc
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------
  chk_idle_no_err: assert property (@(posedge tx_clk) disable iff (!rst_n)
    !tx_en |-> !tx_er) else $error("tx_er high while idle");
  chk_preamble_sfd: assert property (@(posedge tx_clk) disable iff (!rst_n)
    $rose(tx_en) |-> txd == 4'h5 ##14 (tx_en && txd == 4'h5) ##1 (tx_en && txd == 4'hD))
    else $error("preamble or delimiter wrong");
  chk_crs_on_tx: assert property (@(posedge tx_clk) disable iff (!rst_n)
    $rose(tx_en) |-> ##[1:3] crs) else $error("crs missing during transmit");
  // ----------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------
  chk_crs_on_rx: assert property (@(posedge rx_clk) disable iff (!rst_n)
    rx_dv |-> crs) else $error("crs missing during receive");
  chk_crs_on_col: assert property (@(posedge rx_clk) disable iff (!rst_n)
    col |-> crs) else $error("crs low during collision");
  chk_false_code: assert property (@(posedge rx_clk) disable iff (!rst_n)
    (rx_er && !rx_dv) |-> rxd == 4'hE) else $error("reserved receive code");
  // ----------------------------------------------------------
  // Management clock
  // ----------------------------------------------------------
  chk_mdc_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(mdc) |=> mdc [*8] ##1 mdc ##1 !mdc) else $error("mdc high phase wrong");
  chk_mdc_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(mdc) |=> !mdc [*8] ##1 !mdc ##1 mdc) else $error("mdc low phase wrong");
  cover property (@(posedge tx_clk) disable iff (!rst_n) $rose(tx_en));
  cover property (@(posedge rx_clk) disable iff (!rst_n) rx_er && !rx_dv);
  cover property (@(posedge rx_clk) disable iff (!rst_n) rx_er && rx_dv);
  cover property (@(posedge rx_clk) disable iff (!rst_n) col);
endmodule
`default_nettype wire

/* tb/mii_nibble_data_signals_tb.sv */
// Self-checking bench joining both link ends through the interface.
// Assumes the link clock is free running and unrelated to clk_sys.
`default_nettype none
module mii_nibble_data_signals_tb import mii_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 0, clk_line = 0, rst_n = 0;
  logic       spd10 = 0, m_v = 0, m_er = 0, m_fc = 0, m_col = 0, m_sqe = 0;
  logic       mac_fd = 0, tx_valid = 0, tx_last = 0, tx_err = 0, lpbk = 0;
  logic [3:0] m_nib = 0;
  logic [7:0] tx_data = 0;
  logic       line_tx_valid, carrier, collision, tx_ready;
  logic       rx_valid, rx_last, rx_bad, rx_fc;
  logic [4:0] line_tx_sym;
  logic [7:0] rx_data;
  int         err_count = 0, samples_checked = 0, cyc = 0;
  logic [4:0] cap[$];
  logic [9:0] rxq[$];
  bit         fc_seen = 0, dv_seen = 0;

  always #10 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #24 clk_line = ~clk_line;
  end

  mii_if u_mii_if ();
  mii_phy_end u_mii_phy_end (.clk_line(clk_line), .rst_n(rst_n), .loopback(lpbk), .full_duplex(mac_fd),
    .speed_10(spd10), .med_rx_valid(m_v), .med_rx_nibble(m_nib), .med_rx_err(m_er),
    .med_false_carrier(m_fc), .med_col(m_col), .med_sqe(m_sqe), .line_tx_valid(line_tx_valid),
    .line_tx_sym(line_tx_sym), .m(u_mii_if));
  mii_mac_end u_mii_mac_end (.clk_sys(clk_sys), .rst_n(rst_n), .full_duplex(mac_fd), .carrier(carrier),
    .collision(collision), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_err(tx_err),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_bad(rx_bad),
    .rx_false_carrier(rx_fc), .m(u_mii_if));
  mii_checker u_mii_checker (.clk_sys(clk_sys), .rst_n(rst_n), .tx_clk(u_mii_if.tx_clk),
    .rx_clk(u_mii_if.rx_clk), .tx_en(u_mii_if.tx_en), .tx_er(u_mii_if.tx_er), .txd(u_mii_if.txd),
    .rx_dv(u_mii_if.rx_dv), .rx_er(u_mii_if.rx_er), .rxd(u_mii_if.rxd), .crs(u_mii_if.crs),
    .col(u_mii_if.col), .mdc(u_mii_if.mdc));

  // ----------------------------------------------------------
  // Monitors and helpers
  // ----------------------------------------------------------
  always @(negedge clk_line) begin
    if (line_tx_valid === 1'b1) cap.push_back(line_tx_sym);
    if (rx_valid === 1'b1) rxq.push_back({rx_bad, rx_last, rx_data});
    if (rx_fc === 1'b1) fc_seen = 1;
    if (u_mii_if.rx_dv === 1'b1) dv_seen = 1;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_line(input int n);
    repeat (n) @(negedge clk_line);
  endtask

  // The byte is taken at the rising edge after a falling edge that shows ready.
  task automatic send_byte(input logic [7:0] d, input logic l, input logic e);
    int n;
    tx_valid = 1;
    tx_data = d;
    tx_last = l;
    tx_err = e;
    n = 0;
    while (tx_ready !== 1'b1 && n < 100) begin
      @(negedge clk_line);
      n++;
    end
    @(negedge clk_line);
    if (l) tx_valid = 0;
  endtask

  task automatic tx_frame(input logic e, input logic [4:0] s2, input logic [4:0] s3);
    cap = {};
    wait_line(1);
    send_byte(8'hA7, 1'b0, 1'b0);
    send_byte(8'h3C, 1'b1, e);
    wait_line(8);
    chk("line count", 10'd20, 10'(cap.size()));
    for (int i = 0; i < 20 && i < cap.size(); i++)
      chk("line sym", 10'(i < 15 ? 5'h05 : i == 15 ? 5'h0D : i == 16 ? 5'h07 :
          i == 17 ? 5'h0A : i == 18 ? s2 : s3), 10'(cap[i]));
  endtask

  // Idle medium nibbles show the inverse of the last one driven.
  task automatic rx_frame(input logic [15:0] b, input int ei);
    logic [3:0] nb;
    rxq = {};
    for (int i = 0; i < 20; i++) begin
      nb = i < 15 ? 4'h5 : i == 15 ? 4'hD : b[4*(i-16) +: 4];
      @(negedge clk_line);
      m_v = 1;
      m_nib = nb;
      m_er = (i == ei);
    end
    @(negedge clk_line);
    m_v = 0;
    m_er = 0;
    m_nib = ~nb;
    wait_line(6);
    chk("rx count", 10'd2, 10'(rxq.size()));
    chk("rx byte0", {2'b00, b[7:0]}, rxq[0]);
    chk("rx byte1", {ei >= 0, 1'b1, b[15:8]}, rxq[1]);
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    wait_line(4);
    rst_n = 1;
    wait_line(6);
    tx_frame(1'b0, 5'h0C, 5'h03);
    tx_frame(1'b1, 5'h10, 5'h10);
    spd10 = 1;
    wait_line(4);
    tx_frame(1'b1, 5'h0C, 5'h03);
    spd10 = 0;
    chk("echo", 10'd0, 10'(dv_seen));
    rx_frame(16'h4196, -1);
    rx_frame(16'h4196, 17);
    // Loopback: the frame comes back on the receive side and not on the line.
    lpbk = 1;
    wait_line(4);
    cap = {};
    rxq = {};
    send_byte(8'hA7, 1'b0, 1'b0);
    send_byte(8'h3C, 1'b1, 1'b1);
    wait_line(8);
    chk("loop line count", 10'd0, 10'(cap.size()));
    chk("loop rx count", 10'd2, 10'(rxq.size()));
    chk("loop byte0", 10'h0A7, rxq[0]);
    chk("loop byte1", 10'h33C, rxq[1]);
    lpbk = 0;
    wait_line(4);
    @(negedge clk_line);
    m_fc = 1;
    @(negedge clk_line);
    m_fc = 0;
    wait_line(4);
    chk("false carrier", 10'd1, 10'(fc_seen));
    m_col = 1;
    wait_line(6);
    chk("collision", 10'd1, 10'(collision));
    chk("carrier", 10'd1, 10'(carrier));
    m_col = 0;
    m_sqe = 1;
    spd10 = 1;
    wait_line(6);
    chk("sqe slow", 10'd1, 10'(collision));
    spd10 = 0;
    wait_line(6);
    chk("sqe fast", 10'd0, 10'(collision));
    spd10 = 1;
    mac_fd = 1;
    wait_line(6);
    chk("fd collision", 10'd0, 10'(collision));
    chk("fd carrier", 10'd0, 10'(carrier));
    m_sqe = 0;
    spd10 = 0;
    mac_fd = 0;
    wait_line(6);
    chk("idle carrier", 10'd0, 10'(carrier));
    wrap_up();
  end
endmodule
`default_nettype wire
